// ===== bench/motor_driver_config_regs_monitor.sv
module motor_driver_config_regs_monitor (
    input logic core_clk,
    input logic rstn,
    input logic sclk,
    input logic scs_n,
    input logic sdi,
    input logic sdo_o,
    input logic sdo_oe,
    input motor_cfg_pkg::phase_cmd_t [2:0] phase_cmd,
    input logic [2:0] diode_conduct,
    input logic [2:0] current_into,
    input logic limit_trip,
    input motor_cfg_pkg::phase_cmd_t [2:0] gate_drive,
    input logic limit_recirculation_select,
    input logic async_rectify_mode,
    input logic sync_rectify_mode,
    input logic demag_active,
    input motor_cfg_pkg::gain_t sense_amp_gain,
    input motor_cfg_pkg::regulator_ctrl_t regulator_ctrl,
    input logic delay_comp_enable,
    input logic [3:0] delay_comp_target
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // Settings may only move once a frame has closed
    recirc_hold_a:
        assert property (!$stable({limit_recirculation_select, async_rectify_mode, sync_rectify_mode,
            sense_amp_gain}) |-> scs_n && $past(scs_n, 2)) else $error("recirc field moved in frame");
    regulator_hold_a:
        assert property (!$stable(regulator_ctrl) |-> scs_n && $past(scs_n, 2))
        else $error("regulator field moved in frame");
    delay_hold_a:
        assert property (!$stable({delay_comp_enable, delay_comp_target}) |-> scs_n && $past(scs_n, 2))
        else $error("delay field moved in frame");
    demag_on_a:
        assert property (async_rectify_mode && sync_rectify_mode |=> demag_active)
        else $error("demag not raised");
    demag_off_a:
        assert property (!(async_rectify_mode && sync_rectify_mode) |=> !demag_active)
        else $error("demag without both modes");
    oe_idle_a:
        assert property (scs_n [*4] |-> !sdo_oe)
        else $error("sdo driven while deselected");
    oe_start_a:
        assert property ($fell(scs_n) |-> ##[1:4] sdo_oe)
        else $error("sdo not driven in frame");
    coast_a:
        assert property ((limit_trip && limit_recirculation_select && !demag_active) [*6] |-> gate_drive == '0)
        else $error("coast not applied");
    brake_a:
        assert property ((limit_trip && !limit_recirculation_select) [*6] |-> gate_drive == 6'h15)
        else $error("brake not applied");
    pass_a:
        assert property ((!limit_trip && !demag_active && !delay_comp_enable && $stable(phase_cmd)) [*8]
            |-> gate_drive == phase_cmd) else $error("gate does not follow command");
endmodule : motor_driver_config_regs_monitor

bind motor_driver_config_regs motor_driver_config_regs_monitor monitor_inst (.core_clk, .rstn, .sclk, .scs_n,
    .sdi, .sdo_o, .sdo_oe, .phase_cmd, .diode_conduct, .current_into, .limit_trip, .gate_drive,
    .limit_recirculation_select, .async_rectify_mode, .sync_rectify_mode, .demag_active, .sense_amp_gain,
    .regulator_ctrl, .delay_comp_enable, .delay_comp_target);

// ===== bench/test_motor_driver_config_regs.sv
module test_motor_driver_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic sclk = 1'b0;
    logic scs_n = 1'b1;
    logic sdi = 1'b0;
    logic sdo_o, sdo_oe, limit_recirculation_select, async_rectify_mode, sync_rectify_mode, demag_active;
    logic delay_comp_enable;
    logic [3:0] delay_comp_target;
    motor_cfg_pkg::phase_cmd_t [2:0] phase_cmd = '0;
    motor_cfg_pkg::phase_cmd_t [2:0] gate_drive;
    logic [2:0] diode_conduct = '0;
    logic [2:0] current_into = '0;
    logic limit_trip = 1'b0;
    motor_cfg_pkg::gain_t sense_amp_gain;
    motor_cfg_pkg::regulator_ctrl_t regulator_ctrl;
    int error_cnt = 0;
    int samples_checked = 0;
    int lat_off, lat_out, lat_in;
    logic [7:0] q;

    always #4 core_clk = ~core_clk;

    motor_driver_config_regs uut (.core_clk, .rstn, .sclk, .scs_n, .sdi, .sdo_o, .sdo_oe, .phase_cmd,
        .diode_conduct, .current_into, .limit_trip, .gate_drive, .limit_recirculation_select,
        .async_rectify_mode, .sync_rectify_mode, .demag_active, .sense_amp_gain, .regulator_ctrl,
        .delay_comp_enable, .delay_comp_target);

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : ticks

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Five cycles per sclk level keeps clear of the four-cycle minimum
    task automatic xfer(input logic rw, input logic [5:0] a, input logic [7:0] d, input int nb, output logic [7:0] r);
        logic [15:0] w;
        w = {rw, a, 1'b0, d};
        r = 8'h00;
        scs_n <= 1'b0;
        ticks(5);
        for (int i = 15; i > 15 - nb; i--) begin
            sdi <= w[i];
            sclk <= 1'b1;
            ticks(5);
            if (i < 8) r[i] = sdo_o;
            sclk <= 1'b0;
            ticks(5);
        end
        scs_n <= 1'b1;
        ticks(10);
    endtask : xfer

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        xfer(1'b0, a, d, 16, r);
    endtask : wr

    task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
        logic [7:0] r;
        xfer(1'b1, a, 8'h00, 16, r);
        chk(r, exp);
    endtask : rdchk

    // Edges counted until the gate shows a rising high-side command on phase 0
    task automatic lat(input logic into, output int n);
        current_into <= {3{into}};
        phase_cmd <= '0;
        ticks(80);
        phase_cmd <= 6'h02;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (gate_drive !== 6'h02 && n < 500);
    endtask : lat

    task automatic results;
        $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // Stimulus and checks
    // ----------------------------------------
    initial begin
        ticks(20);
        rstn <= 1'b1;
        ticks(4);
        rdchk(motor_cfg_pkg::recirc_addr, 8'h00);
        rdchk(motor_cfg_pkg::regulator_addr, 8'h00);
        rdchk(motor_cfg_pkg::delay_addr, 8'h00);
        wr(motor_cfg_pkg::recirc_addr, 8'hb4);
        rdchk(motor_cfg_pkg::recirc_addr, 8'hb4);
        chk({5'h0, limit_recirculation_select, async_rectify_mode, sync_rectify_mode}, 8'h01);
        wr(motor_cfg_pkg::recirc_addr, 8'h48);
        chk({5'h0, limit_recirculation_select, async_rectify_mode, sync_rectify_mode}, 8'h06);
        for (int g = 0; g < 4; g++) begin
            wr(motor_cfg_pkg::recirc_addr, {6'h03, 2'(g)});
            chk({6'h0, sense_amp_gain}, 8'(g));
        end
        chk({7'h0, demag_active}, 8'h01);
        wr(motor_cfg_pkg::regulator_addr, 8'hff);
        rdchk(motor_cfg_pkg::regulator_addr, 8'h3f);
        for (int v = 0; v < 4; v++) begin
            wr(motor_cfg_pkg::regulator_addr, {3'h0, 5'({v[0], v[1], 2'(v), v[1]})});
            chk({3'h0, regulator_ctrl}, {3'h0, 5'({v[0], v[1], 2'(v), v[1]})});
        end
        lat(1'b0, lat_off);
        chk(8'(lat_off > 3 && lat_off < 8), 8'h01);
        wr(motor_cfg_pkg::delay_addr, 8'hff);
        rdchk(motor_cfg_pkg::delay_addr, 8'h1f);
        chk({3'h0, delay_comp_enable, delay_comp_target}, 8'h1f);
        // Unmapped place and a cut-short frame must leave everything alone
        wr(6'h3f, 8'h5a);
        rdchk(6'h3f, 8'h00);
        xfer(1'b0, motor_cfg_pkg::delay_addr, 8'h00, 12, q);
        rdchk(motor_cfg_pkg::delay_addr, 8'h1f);
        wr(motor_cfg_pkg::delay_addr, 8'h11);
        lat(1'b0, lat_out);
        lat(1'b1, lat_in);
        chk(8'(lat_out - lat_off), 8'(motor_cfg_pkg::dly_step_cycles * 2));
        chk(8'(lat_out - lat_in), 8'(motor_cfg_pkg::dir_skew_cycles));
        wr(motor_cfg_pkg::delay_addr, 8'h00);
        phase_cmd <= '0;
        diode_conduct <= 3'b001;
        ticks(12);
        chk({7'h0, gate_drive[0].lo}, 8'h01);
        wr(motor_cfg_pkg::recirc_addr, 8'h08);
        ticks(12);
        chk({2'h0, gate_drive}, 8'h00);
        diode_conduct <= 3'b000;
        wr(motor_cfg_pkg::recirc_addr, 8'h40);
        limit_trip <= 1'b1;
        phase_cmd <= 6'h2a;
        ticks(12);
        chk({2'h0, gate_drive}, 8'h00);
        wr(motor_cfg_pkg::recirc_addr, 8'h00);
        ticks(12);
        chk({2'h0, gate_drive}, 8'h15);
        limit_trip <= 1'b0;
        ticks(12);
        chk({2'h0, gate_drive}, 8'h2a);
        results();
    end

    initial begin
        #200us;
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        results();
    end
endmodule : test_motor_driver_config_regs

// ===== logic/motor_cfg_pkg.sv
package motor_cfg_pkg;

    // ----------------------------------------
    // Register offsets and reset values
    // ----------------------------------------
    localparam logic [5:0] recirc_addr = 6'h07;
    localparam logic [5:0] regulator_addr = 6'h08;
    localparam logic [5:0] delay_addr = 6'h0c;
    localparam logic [7:0] recirc_reset = 8'h00;
    localparam logic [7:0] regulator_reset = 8'h00;
    localparam logic [7:0] delay_reset = 8'h00;
    // Read-only zero bits are masked off on write
    localparam logic [7:0] recirc_wmask = 8'hff;
    localparam logic [7:0] regulator_wmask = 8'h3f;
    localparam logic [7:0] delay_wmask = 8'h1f;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int recirc_sel_bit = 6;
    localparam int async_en_bit = 3;
    localparam int sync_en_bit = 2;
    localparam int gain_lsb = 0;
    localparam int seq_dis_bit = 4;
    localparam int cur_lim_bit = 3;
    localparam int volt_lsb = 1;
    localparam int reg_off_bit = 0;
    localparam int dly_en_bit = 4;
    localparam int delay_comp_target_lsb = 0;

    // ----------------------------------------
    // Serial frame layout
    // ----------------------------------------
    localparam logic [4:0] frame_len = 5'h10;
    localparam logic [4:0] addr_done_cnt = 5'h07;
    localparam int rw_bit = 15;
    localparam int addr_lsb = 9;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int clk_period_ns = 8;
    localparam int dly_step_ns = 200;
    localparam int dly_step_cycles = dly_step_ns / clk_period_ns;
    // Intrinsic edge skew of the stage when current flows into the phase
    localparam int dir_skew_ns = 40;
    localparam int dir_skew_cycles = (dir_skew_ns / clk_period_ns < 1) ? 1 : dir_skew_ns / clk_period_ns;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {logic hi; logic lo;} phase_cmd_t;
    typedef struct packed {logic seq_dis; logic cur_lim; logic [1:0] volt_sel; logic off;} regulator_ctrl_t;
    typedef struct packed {logic rd; logic wr; logic [5:0] addr; logic [7:0] wdata;} reg_req_t;
    typedef enum logic [1:0] {gain_0v15 = 2'b00, gain_0v3 = 2'b01, gain_0v6 = 2'b10, gain_1v2 = 2'b11} gain_t;
    typedef enum logic [1:0] {port_idle = 2'b00, port_shift = 2'b01, port_hold = 2'b10} port_state_t;

endpackage : motor_cfg_pkg

// ===== logic/motor_driver_config_regs.sv
// Overview of operation
// RULE_01: Bit 6 picks brake or coast recirculation.
// RULE_02: Bit 3 enables asynchronous rectification mode.
// RULE_03: Bit 2 enables synchronous rectification mode.
// RULE_04: Gain code selects 0.15 to 1.2 V/A.
// RULE_05: Regulator bit 4 set disables power sequencing.
// RULE_06: Regulator bit 3 picks 600 or 150 mA.
// RULE_07: Voltage code selects 3.3, 5.0, 4.0, 5.7 V.
// RULE_08: Regulator bit 0 set turns regulator off.
// RULE_09: One bit enables driver delay compensation.
// RULE_10: Target code 0 is zero, else 0.2us steps.
// RULE_11: Compensation pads each output edge to target.
// RULE_12: Both rectify enables give active demagnetization.
// RULE_13: Software writes zeros to reserved bits.
module motor_driver_config_regs (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    input wire motor_cfg_pkg::phase_cmd_t [2:0] phase_cmd,
    input wire logic [2:0] diode_conduct,
    input wire logic [2:0] current_into,
    input wire logic limit_trip,
    output motor_cfg_pkg::phase_cmd_t [2:0] gate_drive,
    output logic limit_recirculation_select,
    output logic async_rectify_mode,
    output logic sync_rectify_mode,
    output logic demag_active,
    output motor_cfg_pkg::gain_t sense_amp_gain,
    output motor_cfg_pkg::regulator_ctrl_t regulator_ctrl,
    output logic delay_comp_enable,
    output logic [3:0] delay_comp_target
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Phase commands and sensors arrive from pins, so two stages each
    logic [12:0] pin_meta_r;
    logic [12:0] pin_sync_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta_r <= 13'h0000;
            pin_sync_r <= 13'h0000;
        end else begin
            pin_meta_r <= {phase_cmd, diode_conduct, current_into, limit_trip};
            pin_sync_r <= pin_meta_r;
        end
    end

    motor_cfg_pkg::phase_cmd_t [2:0] cmd_s;
    logic [2:0] diode_s;
    logic [2:0] into_s;
    logic limit_s;
    assign cmd_s = pin_sync_r[12:7];
    assign diode_s = pin_sync_r[6:4];
    assign into_s = pin_sync_r[3:1];
    assign limit_s = pin_sync_r[0];

    // ----------------------------------------
    // Serial configuration port
    // ----------------------------------------
    motor_cfg_pkg::reg_req_t req;
    logic [7:0] rdata;

    serial_cfg_port port_u (
        .core_clk(core_clk),
        .rstn(rstn),
        .sclk(sclk),
        .scs_n(scs_n),
        .sdi(sdi),
        .rdata(rdata),
        .req(req),
        .sdo_o(sdo_o),
        .sdo_oe(sdo_oe)
    );

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] recirc_r;
    logic [7:0] regulator_r;
    logic [7:0] delay_r;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            recirc_r <= motor_cfg_pkg::recirc_reset;
        end else if (req.wr && req.addr == motor_cfg_pkg::recirc_addr) begin
            recirc_r <= req.wdata & motor_cfg_pkg::recirc_wmask;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            regulator_r <= motor_cfg_pkg::regulator_reset; // [RULE_08]
        end else if (req.wr && req.addr == motor_cfg_pkg::regulator_addr) begin
            // Read-only zero bits never store, whatever software sends
            regulator_r <= req.wdata & motor_cfg_pkg::regulator_wmask; // [RULE_13]
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            delay_r <= motor_cfg_pkg::delay_reset;
        end else if (req.wr && req.addr == motor_cfg_pkg::delay_addr) begin
            delay_r <= req.wdata & motor_cfg_pkg::delay_wmask;
        end
    end

    // ----------------------------------------
    // Read-back
    // ----------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        case (req.addr)
            motor_cfg_pkg::recirc_addr: rdata = recirc_r;
            motor_cfg_pkg::regulator_addr: rdata = regulator_r;
            motor_cfg_pkg::delay_addr: rdata = delay_r;
            default: rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Field outputs
    // ----------------------------------------
    assign limit_recirculation_select = recirc_r[motor_cfg_pkg::recirc_sel_bit]; // [RULE_01]
    assign async_rectify_mode = recirc_r[motor_cfg_pkg::async_en_bit]; // [RULE_02]
    assign sync_rectify_mode = recirc_r[motor_cfg_pkg::sync_en_bit]; // [RULE_03]
    assign sense_amp_gain = motor_cfg_pkg::gain_t'(recirc_r[motor_cfg_pkg::gain_lsb +: 2]); // [RULE_04]
    assign regulator_ctrl.seq_dis = regulator_r[motor_cfg_pkg::seq_dis_bit]; // [RULE_05]
    assign regulator_ctrl.cur_lim = regulator_r[motor_cfg_pkg::cur_lim_bit]; // [RULE_06]
    assign regulator_ctrl.volt_sel = regulator_r[motor_cfg_pkg::volt_lsb +: 2]; // [RULE_07]
    assign regulator_ctrl.off = regulator_r[motor_cfg_pkg::reg_off_bit]; // [RULE_08]
    assign delay_comp_enable = delay_r[motor_cfg_pkg::dly_en_bit]; // [RULE_09]
    assign delay_comp_target = delay_r[motor_cfg_pkg::delay_comp_target_lsb +: 4];

    // ----------------------------------------
    // Delay target in cycles
    // ----------------------------------------
    // Code n above zero means (n + 1) steps of 0.2 us
    logic [8:0] target_cyc;
    always_comb begin
        if (!delay_comp_enable || delay_comp_target == 4'h0) begin
            target_cyc = 9'h000; // [RULE_10]
        end else begin
            target_cyc = 9'((5'({1'b0, delay_comp_target}) + 5'h01) * motor_cfg_pkg::dly_step_cycles); // [RULE_10]
        end
    end

    // Demagnetization needs both rectification modes at once
    logic demag_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            demag_r <= 1'b0;
        end else begin
            demag_r <= async_rectify_mode & sync_rectify_mode; // [RULE_12]
        end
    end
    assign demag_active = demag_r;

    // ----------------------------------------
    // Per-phase delay compensation and gating
    // ----------------------------------------
    localparam logic [8:0] skew_cyc = 9'(motor_cfg_pkg::dir_skew_cycles);

    genvar ph;
    generate
        for (ph = 0; ph < 3; ph++) begin : g_phase
            motor_cfg_pkg::phase_cmd_t pend_r;
            motor_cfg_pkg::phase_cmd_t dly_r;
            motor_cfg_pkg::phase_cmd_t gate_r;
            logic [8:0] cnt_r;
            logic [8:0] added_cyc;

            // Current into the phase already runs late by the skew, so pad less
            always_comb begin
                if (into_s[ph] && target_cyc > skew_cyc) begin
                    added_cyc = target_cyc - skew_cyc; // [RULE_11]
                end else if (into_s[ph]) begin
                    added_cyc = 9'h000;
                end else begin
                    added_cyc = target_cyc; // [RULE_11]
                end
            end

            // A command that flips back before its delay ends is dropped
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    pend_r <= '0;
                    dly_r <= '0;
                    cnt_r <= 9'h000;
                end else if (cmd_s[ph] != pend_r) begin
                    pend_r <= cmd_s[ph];
                    cnt_r <= 9'h000;
                end else if (dly_r != pend_r) begin
                    if (cnt_r >= added_cyc) begin
                        dly_r <= pend_r; // [RULE_11]
                        cnt_r <= 9'h000;
                    end else begin
                        cnt_r <= cnt_r + 9'h001;
                    end
                end
            end

            // Limit trip overrides the command; while demag_r is set, a conducting diode is bypassed
            always_ff @(posedge core_clk or negedge rstn) begin
                if (!rstn) begin
                    gate_r <= '0;
                end else if (limit_s) begin
                    gate_r.hi <= 1'b0;
                    gate_r.lo <= ~limit_recirculation_select; // [RULE_01]
                end else begin
                    gate_r.hi <= dly_r.hi;
                    gate_r.lo <= dly_r.lo | (demag_r & diode_s[ph] & ~dly_r.hi); // [RULE_12]
                end
            end

            assign gate_drive[ph] = gate_r;
        end
    endgenerate

endmodule : motor_driver_config_regs

// ===== logic/serial_cfg_port.sv
module serial_cfg_port (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic sclk,
    input wire logic scs_n,
    input wire logic sdi,
    input wire logic [7:0] rdata,
    output motor_cfg_pkg::reg_req_t req,
    output logic sdo_o,
    output logic sdo_oe
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic sclk_prev_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            // Idle pin levels: deselected, clock low, so no false edge follows reset
            meta_r <= 3'h4;
            sync_r <= 3'h4;
            sclk_prev_r <= 1'b0;
        end else begin
            meta_r <= {scs_n, sclk, sdi};
            sync_r <= meta_r;
            sclk_prev_r <= sync_r[1];
        end
    end
    logic cs_s, sclk_s, sdi_s, sclk_rise, sclk_fall;
    assign cs_s = ~sync_r[2];
    assign sclk_s = sync_r[1];
    assign sdi_s = sync_r[0];
    assign sclk_rise = sclk_s & ~sclk_prev_r;
    assign sclk_fall = ~sclk_s & sclk_prev_r;

    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    motor_cfg_pkg::port_state_t state_r;
    logic [15:0] shift_r;
    logic [4:0] cnt_r;
    logic [7:0] rdata_r;
    logic rd_r, wr_r, sdo_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= motor_cfg_pkg::port_idle;
            shift_r <= 16'h0000;
            cnt_r <= 5'h00;
            rdata_r <= 8'h00;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            sdo_r <= 1'b0;
        end else begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            if (rd_r) begin
                rdata_r <= rdata;
            end
            case (state_r)
                motor_cfg_pkg::port_idle: begin
                    if (cs_s) begin
                        state_r <= motor_cfg_pkg::port_shift;
                        cnt_r <= 5'h00;
                        sdo_r <= 1'b0;
                        rdata_r <= 8'h00;
                    end
                end
                motor_cfg_pkg::port_shift, motor_cfg_pkg::port_hold: begin
                    if (!cs_s) begin
                        // Only a whole write frame commits, so a torn frame changes nothing
                        wr_r <= (cnt_r == motor_cfg_pkg::frame_len) & ~shift_r[motor_cfg_pkg::rw_bit];
                        state_r <= motor_cfg_pkg::port_idle;
                    end else if (state_r == motor_cfg_pkg::port_shift && sclk_fall) begin
                        shift_r <= {shift_r[14:0], sdi_s};
                        cnt_r <= cnt_r + 5'h01;
                        rd_r <= (cnt_r + 5'h01) == motor_cfg_pkg::addr_done_cnt;
                        if ((cnt_r + 5'h01) == motor_cfg_pkg::frame_len) begin
                            state_r <= motor_cfg_pkg::port_hold;
                        end
                    end else if (state_r == motor_cfg_pkg::port_shift && sclk_rise) begin
                        sdo_r <= cnt_r[3] & rdata_r[~cnt_r[2:0]];
                    end
                end
                default: state_r <= motor_cfg_pkg::port_idle;
            endcase
        end
    end

    assign req.rd = rd_r;
    assign req.wr = wr_r;
    assign req.addr = (state_r == motor_cfg_pkg::port_shift && cnt_r == motor_cfg_pkg::addr_done_cnt) ?
        shift_r[5:0] : shift_r[14:motor_cfg_pkg::addr_lsb];
    assign req.wdata = shift_r[7:0];
    assign sdo_o = sdo_r;
    assign sdo_oe = state_r != motor_cfg_pkg::port_idle;

endmodule : serial_cfg_port
